// [verilog/uecs_top.sv]
// Purpose: endpoint control/status registers behind a byte register port
// Assumes: engine signals are on clk; firmware keeps index in 0..5
// Notes: controller enable clear holds every endpoint flag in reset
`timescale 1ns/10ps
`default_nettype none
module uecs_top #(
	parameter int NUM_IN = 5
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [15:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	output logic usbEnable,
	input wire logic ep0IntEnable,
	input wire logic ep0RxPacket,
	input wire logic ep0TxDone,
	input wire logic ep0StallSent,
	input wire logic ep0EarlyEnd,
	input wire logic ep0DataEndDone,
	output logic ep0FifoFlush,
	output logic ep0StallReq,
	output logic ep0DataEnd,
	output logic ep0TxReady,
	output logic ep0RxReady,
	output logic ep0IntReq,
	input wire logic [NUM_IN:1] inIntEnable,
	input wire logic [NUM_IN:1] inIsoMode,
	input wire logic [NUM_IN:1] inTxDone,
	input wire logic [NUM_IN:1] inStallSent,
	input wire logic [NUM_IN:1] inTokenNoData,
	input wire logic [NUM_IN:1] inFifoHasPacket,
	output logic [NUM_IN:1] inTxReady,
	output logic [NUM_IN:1] inStallMode,
	output logic [NUM_IN:1] inFifoFlush,
	output logic [NUM_IN:1] inToggleReset,
	output logic [NUM_IN:1] inZeroLenReq,
	output logic [NUM_IN:1] inIntReq
);
	localparam logic [3:0] IN_LAST = 4'(NUM_IN);

	logic [3:0] index_q, index_d;
	logic enable_q, enable_d;
	logic [7:0] rdata_q, rdata_d;
	logic csrWr, selEp0, selIn;
	logic [7:0] inCsr [NUM_IN:1];
	logic [7:0] selInCsr;

	uecs_ep_if ep0Bus();

	// Endpoint view chosen by the index
	always_comb begin
		selEp0 = (index_q == 4'h0); // RULE_01
		selIn = (index_q != 4'h0) && (index_q <= IN_LAST); // RULE_01 RULE_19
		csrWr = regWr && (regAddr == uecs_pkg::ADDR_CSR) && enable_q;
	end

	assign ep0Bus.wr = csrWr && selEp0; // RULE_01
	assign ep0Bus.wdata = regWdata;
	assign ep0Bus.clr = ~enable_q; // RULE_20

	uecs_ep0 u_ep0 (
		.clk(clk),
		.sys_rst(sys_rst),
		.bus(ep0Bus),
		.intEnable(ep0IntEnable),
		.rxPacket(ep0RxPacket),
		.txDone(ep0TxDone),
		.stallSent(ep0StallSent),
		.earlyEnd(ep0EarlyEnd),
		.dataEndDone(ep0DataEndDone),
		.fifoFlush(ep0FifoFlush),
		.stallReq(ep0StallReq),
		.dataEnd(ep0DataEnd),
		.txReady(ep0TxReady),
		.rxReady(ep0RxReady),
		.intReq(ep0IntReq)
	);

	for (genvar gi = 1; gi <= NUM_IN; gi++) begin : g_in
		uecs_ep_if inBus();
		assign inBus.wr = csrWr && selIn && (index_q == 4'(gi)); // RULE_01
		assign inBus.wdata = regWdata;
		assign inBus.clr = ~enable_q; // RULE_20
		assign inCsr[gi] = inBus.csr;
		uecs_in_ep u_in (
			.clk(clk),
			.sys_rst(sys_rst),
			.bus(inBus),
			.intEnable(inIntEnable[gi]),
			.isoMode(inIsoMode[gi]),
			.txDone(inTxDone[gi]),
			.stallSent(inStallSent[gi]),
			.tokenNoData(inTokenNoData[gi]),
			.fifoHasPacket(inFifoHasPacket[gi]),
			.txReady(inTxReady[gi]),
			.stallMode(inStallMode[gi]),
			.fifoFlush(inFifoFlush[gi]),
			.toggleReset(inToggleReset[gi]),
			.zeroLenReq(inZeroLenReq[gi]),
			.intReq(inIntReq[gi])
		);
	end

	always_comb begin
		selInCsr = 8'h00;
		for (int i = 1; i <= NUM_IN; i++) begin
			if (index_q == 4'(i)) begin
				selInCsr = inCsr[i];
			end
		end
	end

	// Index and enable registers, read data one cycle after the strobe
	always_comb begin
		index_d = index_q;
		enable_d = enable_q;
		rdata_d = 8'h00;
		if (regWr && (regAddr == uecs_pkg::ADDR_INDEX)) begin
			index_d = regWdata[3:0];
		end else if (regWr && (regAddr == uecs_pkg::ADDR_CTRL)) begin
			enable_d = regWdata[uecs_pkg::CTRL_ENABLE_BIT];
		end
		if (!enable_q) begin
			index_d = uecs_pkg::INDEX_RESET; // RULE_20
		end
		if (regRd) begin
			if (regAddr == uecs_pkg::ADDR_INDEX) begin
				rdata_d = {4'h0, index_q};
			end else if (regAddr == uecs_pkg::ADDR_CTRL) begin
				rdata_d = {7'h00, enable_q};
			end else if (regAddr == uecs_pkg::ADDR_CSR && selEp0) begin
				rdata_d = ep0Bus.csr; // RULE_01
			end else if (regAddr == uecs_pkg::ADDR_CSR && selIn) begin
				rdata_d = selInCsr; // RULE_01
			end else begin
				rdata_d = uecs_pkg::CSR_RESET;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			index_q <= uecs_pkg::INDEX_RESET;
			enable_q <= uecs_pkg::ENABLE_RESET;
			rdata_q <= 8'h00;
		end else begin
			index_q <= index_d;
			enable_q <= enable_d;
			rdata_q <= rdata_d;
		end
	end

	assign regRdata = rdata_q;
	assign usbEnable = enable_q;
endmodule
`default_nettype wire

// [verilog/uecs_pkg.sv]
// Purpose: constants shared by the endpoint control/status block
// Assumes: byte-wide register port, controller clock only
// Notes: bit positions index the 8-bit control/status views
// Behaviour
// [RULE_01] Status address shows endpoint-0 view at index zero, IN view at one-five.
// [RULE_02] Writing one to endpoint-0 bit 7 clears the early-end flag; strobe self-clears.
// [RULE_03] Early control end sets bit 4, flushes endpoint-0 FIFO, requests interrupt.
// [RULE_04] Received endpoint-0 packet sets bit 0 and requests interrupt when enabled.
// [RULE_05] Writing one to bit 6 drops endpoint-0 receive-ready; strobe self-clears.
// [RULE_06] Endpoint-0 bit 5 makes controller answer STALL, then clears itself.
// [RULE_07] Firmware sets data-end with last packet or zero-length packet.
// [RULE_08] Endpoint-0 data-end bit clears itself once the controller acts on it.
// [RULE_09] Sent STALL sets endpoint-0 bit 2, requests interrupt; firmware clears it.
// [RULE_10] Endpoint-0 transmit-ready clears after sending, with interrupt request.
// [RULE_11] Writing one to IN bit 6 resets data toggle to DATA0; self-clears.
// [RULE_12] IN STALL sent sets bit 5, flushes FIFO, clears ready, requests interrupt.
// [RULE_13] IN bit 4 stalls every IN token, bulk or interrupt only.
// [RULE_14] IN bit 3 flushes next packet, clears ready, self-clears.
// [RULE_15] Isochronous IN token without ready sets underrun, sends zero-length packet.
// [RULE_16] Bulk or interrupt NAK to IN token sets underrun; firmware clears.
// [RULE_17] Bit 1 reads one whenever the IN FIFO holds a packet.
// [RULE_18] IN transmit-ready clears after sending, with interrupt request.
// [RULE_19] Firmware programs the endpoint index only with values zero to five.
// [RULE_20] Clearing the controller enable resets all endpoint control and status.
// [RULE_21] Writing zero to strobes does nothing; strobes read back zero.
package uecs_pkg;
	localparam logic [15:0] ADDR_INDEX = 16'h620E;
	localparam logic [15:0] ADDR_CTRL = 16'h620F;
	localparam logic [15:0] ADDR_CSR = 16'h6211;
	localparam logic [3:0] INDEX_RESET = 4'h0;
	localparam logic ENABLE_RESET = 1'b0;
	localparam logic [7:0] CSR_RESET = 8'h00;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int EP0_CLR_END_BIT = 7;
	localparam int EP0_CLR_RX_BIT = 6;
	localparam int EP0_SEND_STALL_BIT = 5;
	localparam int EP0_EARLY_END_BIT = 4;
	localparam int EP0_DATA_END_BIT = 3;
	localparam int EP0_SENT_STALL_BIT = 2;
	localparam int EP0_TX_READY_BIT = 1;
	localparam int EP0_RX_READY_BIT = 0;
	localparam int IN_TOGGLE_RESET_BIT = 6;
	localparam int IN_SENT_STALL_BIT = 5;
	localparam int IN_SEND_STALL_BIT = 4;
	localparam int IN_FLUSH_BIT = 3;
	localparam int IN_UNDERRUN_BIT = 2;
	localparam int IN_NONEMPTY_BIT = 1;
	localparam int IN_TX_READY_BIT = 0;
endpackage

// [verilog/uecs_ep_if.sv]
// Purpose: register access path from the decoder to one endpoint
// Assumes: write is a one-cycle strobe, csr is the live view
// Notes: clr holds the endpoint in reset while the controller is off
`timescale 1ns/10ps
`default_nettype none
interface uecs_ep_if;
	logic wr;
	logic [7:0] wdata;
	logic clr;
	logic [7:0] csr;
	modport ctrl(output wr, output wdata, output clr, input csr);
	modport ep(input wr, input wdata, input clr, output csr);
endinterface
`default_nettype wire

// [verilog/uecs_ep0.sv]
// Purpose: endpoint-0 control transfer flags
// Assumes: engine events are one-cycle pulses on clk
// Notes: a hardware set beats a software clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module uecs_ep0 (
	input wire logic clk,
	input wire logic sys_rst,
	uecs_ep_if.ep bus,
	input wire logic intEnable,
	input wire logic rxPacket,
	input wire logic txDone,
	input wire logic stallSent,
	input wire logic earlyEnd,
	input wire logic dataEndDone,
	output logic fifoFlush,
	output logic stallReq,
	output logic dataEnd,
	output logic txReady,
	output logic rxReady,
	output logic intReq
);
	logic rx_q, rx_d, tx_q, tx_d, stall_q, stall_d, sent_q, sent_d;
	logic end_q, end_d, dend_q, dend_d, flush_q, flush_d, irq_q, irq_d;
	logic [7:0] w;

	always_comb begin
		w = bus.wr ? bus.wdata : 8'h00;
		rx_d = rxPacket | (rx_q & ~w[uecs_pkg::EP0_CLR_RX_BIT]); // RULE_04 RULE_05
		tx_d = w[uecs_pkg::EP0_TX_READY_BIT] | (tx_q & ~txDone); // RULE_10
		stall_d = w[uecs_pkg::EP0_SEND_STALL_BIT] | (stall_q & ~stallSent); // RULE_06
		sent_d = stallSent | (sent_q & ~(bus.wr &
			~bus.wdata[uecs_pkg::EP0_SENT_STALL_BIT])); // RULE_09
		end_d = earlyEnd | (end_q & ~w[uecs_pkg::EP0_CLR_END_BIT]); // RULE_02
		dend_d = w[uecs_pkg::EP0_DATA_END_BIT] | (dend_q & ~dataEndDone); // RULE_08
		flush_d = earlyEnd; // RULE_03
		irq_d = intEnable & (rxPacket | txDone | stallSent | earlyEnd); // RULE_03
		if (bus.clr) begin
			rx_d = 1'b0;
			tx_d = 1'b0;
			stall_d = 1'b0;
			sent_d = 1'b0;
			end_d = 1'b0;
			dend_d = 1'b0;
			flush_d = 1'b0;
			irq_d = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_q <= 1'b0;
			tx_q <= 1'b0;
			stall_q <= 1'b0;
			sent_q <= 1'b0;
			end_q <= 1'b0;
			dend_q <= 1'b0;
			flush_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			rx_q <= rx_d;
			tx_q <= tx_d;
			stall_q <= stall_d;
			sent_q <= sent_d;
			end_q <= end_d;
			dend_q <= dend_d;
			flush_q <= flush_d;
			irq_q <= irq_d;
		end
	end

	// Strobe bits 7 and 6 read zero
	assign bus.csr = {2'b00, stall_q, end_q, dend_q, sent_q, tx_q, rx_q}; // RULE_21
	assign fifoFlush = flush_q;
	assign stallReq = stall_q;
	assign dataEnd = dend_q;
	assign txReady = tx_q;
	assign rxReady = rx_q;
	assign intReq = irq_q;
endmodule
`default_nettype wire

// [verilog/uecs_in_ep.sv]
// Purpose: low control/status flags of one IN endpoint
// Assumes: engine events are one-cycle pulses on clk
// Notes: flush or a sent STALL clears ready even if set in the same write
`timescale 1ns/10ps
`default_nettype none
module uecs_in_ep (
	input wire logic clk,
	input wire logic sys_rst,
	uecs_ep_if.ep bus,
	input wire logic intEnable,
	input wire logic isoMode,
	input wire logic txDone,
	input wire logic stallSent,
	input wire logic tokenNoData,
	input wire logic fifoHasPacket,
	output logic txReady,
	output logic stallMode,
	output logic fifoFlush,
	output logic toggleReset,
	output logic zeroLenReq,
	output logic intReq
);
	logic tx_q, tx_d, sent_q, sent_d, send_q, send_d, und_q, und_d;
	logic pres_q, pres_d, mode_q, mode_d, flush_q, flush_d;
	logic tog_q, tog_d, zlp_q, zlp_d, irq_q, irq_d;
	logic [7:0] w;

	always_comb begin
		w = bus.wr ? bus.wdata : 8'h00;
		tog_d = w[uecs_pkg::IN_TOGGLE_RESET_BIT]; // RULE_11
		flush_d = w[uecs_pkg::IN_FLUSH_BIT] | stallSent; // RULE_14 RULE_12
		tx_d = (w[uecs_pkg::IN_TX_READY_BIT] | (tx_q & ~txDone))
			& ~flush_d; // RULE_18 RULE_14 RULE_12
		sent_d = stallSent | (sent_q & ~(bus.wr &
			~bus.wdata[uecs_pkg::IN_SENT_STALL_BIT])); // RULE_12
		send_d = bus.wr ? bus.wdata[uecs_pkg::IN_SEND_STALL_BIT] : send_q;
		mode_d = send_d & ~isoMode; // RULE_13
		und_d = tokenNoData | (und_q & ~(bus.wr &
			~bus.wdata[uecs_pkg::IN_UNDERRUN_BIT])); // RULE_15 RULE_16
		zlp_d = tokenNoData & isoMode; // RULE_15
		pres_d = fifoHasPacket; // RULE_17
		irq_d = intEnable & (txDone | stallSent); // RULE_18 RULE_12
		if (bus.clr) begin
			tog_d = 1'b0;
			flush_d = 1'b0;
			tx_d = 1'b0;
			sent_d = 1'b0;
			send_d = 1'b0;
			mode_d = 1'b0;
			und_d = 1'b0;
			zlp_d = 1'b0;
			pres_d = 1'b0;
			irq_d = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tog_q <= 1'b0;
			flush_q <= 1'b0;
			tx_q <= 1'b0;
			sent_q <= 1'b0;
			send_q <= 1'b0;
			mode_q <= 1'b0;
			und_q <= 1'b0;
			zlp_q <= 1'b0;
			pres_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			tog_q <= tog_d;
			flush_q <= flush_d;
			tx_q <= tx_d;
			sent_q <= sent_d;
			send_q <= send_d;
			mode_q <= mode_d;
			und_q <= und_d;
			zlp_q <= zlp_d;
			pres_q <= pres_d;
			irq_q <= irq_d;
		end
	end

	// Reserved bit 7 and strobes 6 and 3 read zero
	assign bus.csr = {2'b00, sent_q, send_q, 1'b0, und_q, pres_q,
		tx_q}; // RULE_21
	assign txReady = tx_q;
	assign stallMode = mode_q;
	assign fifoFlush = flush_q;
	assign toggleReset = tog_q;
	assign zeroLenReq = zlp_q;
	assign intReq = irq_q;
endmodule
`default_nettype wire

// [tb/uecs_chk_sva.sv]
// Purpose: port checks of endpoint control/status
// Assumes: engine events are one-cycle pulses
// Notes: bound to uecs_top below
`timescale 1ns/10ps
`default_nettype none
module uecs_chk #(
	parameter int NUM_IN = 5
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic regWr,
	input wire logic usbEnable,
	input wire logic ep0IntEnable,
	input wire logic ep0RxPacket,
	input wire logic ep0TxDone,
	input wire logic ep0StallSent,
	input wire logic ep0EarlyEnd,
	input wire logic ep0DataEndDone,
	input wire logic ep0FifoFlush,
	input wire logic ep0StallReq,
	input wire logic ep0DataEnd,
	input wire logic ep0TxReady,
	input wire logic ep0RxReady,
	input wire logic ep0IntReq,
	input wire logic [NUM_IN:1] inIsoMode,
	input wire logic [NUM_IN:1] inStallSent,
	input wire logic [NUM_IN:1] inTxReady,
	input wire logic [NUM_IN:1] inStallMode,
	input wire logic [NUM_IN:1] inFifoFlush,
	input wire logic [NUM_IN:1] inIntEnable,
	input wire logic [NUM_IN:1] inTxDone,
	input wire logic [NUM_IN:1] inTokenNoData,
	input wire logic [NUM_IN:1] inZeroLenReq,
	input wire logic [NUM_IN:1] inIntReq
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_EP0_RX: assert property (ep0RxPacket && usbEnable |=> ep0RxReady)
		else $error("rx ready not set");
	AST_EP0_INT: assert property ((ep0RxPacket || ep0TxDone || ep0StallSent
		|| ep0EarlyEnd) && ep0IntEnable && usbEnable |=> ep0IntReq)
		else $error("ep0 interrupt missing");
	AST_EP0_FLUSH: assert property (ep0EarlyEnd && usbEnable |=> ep0FifoFlush)
		else $error("ep0 flush missing");
	AST_EP0_STALL: assert property (ep0StallSent && !regWr |=> !ep0StallReq)
		else $error("send stall kept");
	AST_EP0_TX: assert property (ep0TxDone && !regWr |=> !ep0TxReady)
		else $error("tx ready kept");
	AST_EP0_DEND: assert property (ep0DataEndDone && !regWr |=> !ep0DataEnd)
		else $error("data end kept");
	AST_IN_STALL: assert property (inStallSent != '0 && usbEnable |=>
		(inFifoFlush & $past(inStallSent)) == $past(inStallSent)
		&& (inTxReady & $past(inStallSent)) == '0)
		else $error("in stall sent effects missing");
	AST_IN_ISO: assert property ((inStallMode & inIsoMode & $past(inIsoMode)) == '0)
		else $error("iso endpoint stalled");
	AST_OFF: assert property (!usbEnable ##1 !usbEnable |->
		!ep0TxReady && !ep0RxReady && inTxReady == '0)
		else $error("flags live while disabled");
	AST_EP0_IRQ: assert property (usbEnable |=>
		ep0IntReq == $past(ep0IntEnable && (ep0RxPacket || ep0TxDone
		|| ep0StallSent || ep0EarlyEnd)))
		else $error("ep0 interrupt request wrong");
	AST_IN_ZLP: assert property (usbEnable |=>
		inZeroLenReq == $past(inTokenNoData & inIsoMode))
		else $error("zero length request wrong");
	AST_IN_INT: assert property (usbEnable |=>
		inIntReq == $past(inIntEnable & (inTxDone | inStallSent)))
		else $error("in interrupt request wrong");
endmodule
bind uecs_top uecs_chk #(.NUM_IN(NUM_IN)) i_chk (.clk(clk), .sys_rst(sys_rst),
	.regWr(regWr), .usbEnable(usbEnable), .ep0IntEnable(ep0IntEnable),
	.ep0RxPacket(ep0RxPacket), .ep0TxDone(ep0TxDone),
	.ep0StallSent(ep0StallSent), .ep0EarlyEnd(ep0EarlyEnd),
	.ep0DataEndDone(ep0DataEndDone), .ep0FifoFlush(ep0FifoFlush),
	.ep0StallReq(ep0StallReq), .ep0DataEnd(ep0DataEnd),
	.ep0TxReady(ep0TxReady), .ep0RxReady(ep0RxReady), .ep0IntReq(ep0IntReq),
	.inIsoMode(inIsoMode), .inStallSent(inStallSent), .inTxReady(inTxReady),
	.inStallMode(inStallMode), .inFifoFlush(inFifoFlush),
	.inIntEnable(inIntEnable), .inTxDone(inTxDone),
	.inTokenNoData(inTokenNoData), .inZeroLenReq(inZeroLenReq),
	.inIntReq(inIntReq));
`default_nettype wire

// [tb/uecs_host_model.sv]
// Purpose: host and protocol engine answering tokens
// Assumes: token bit 0 is endpoint 0, bits 5:1 IN
// Notes: answers one cycle after each request
`timescale 1ns/10ps
`default_nettype none
module uecs_host_model (
	input wire logic clk,
	input wire logic sysRst,
	input wire logic [5:0] token,
	input wire logic outPkt,
	input wire logic abortXfer,
	input wire logic ep0StallReq,
	input wire logic ep0TxReady,
	input wire logic ep0DataEnd,
	input wire logic [5:1] inStallMode,
	input wire logic [5:1] inTxReady,
	output logic ep0RxPacket,
	output logic ep0TxDone,
	output logic ep0StallSent,
	output logic ep0EarlyEnd,
	output logic ep0DataEndDone,
	output logic [5:1] inTxDone,
	output logic [5:1] inStallSent,
	output logic [5:1] inTokenNoData
);
	logic go;
	assign go = token[0] && !ep0StallReq;
	always_ff @(posedge clk or posedge sysRst) begin
		if (sysRst) begin
			{ep0RxPacket, ep0TxDone, ep0StallSent, ep0EarlyEnd} <= 4'h0;
			ep0DataEndDone <= 1'b0;
			{inTxDone, inStallSent, inTokenNoData} <= 15'h0000;
		end else begin
			ep0RxPacket <= outPkt;
			ep0EarlyEnd <= abortXfer;
			ep0StallSent <= token[0] && ep0StallReq;
			ep0TxDone <= go && ep0TxReady;
			ep0DataEndDone <= go && ep0DataEnd;
			inStallSent <= token[5:1] & inStallMode;
			inTxDone <= token[5:1] & ~inStallMode & inTxReady;
			inTokenNoData <= token[5:1] & ~inStallMode & ~inTxReady;
		end
	end
endmodule
`default_nettype wire

// [tb/tb_usb_endpoint_ctrl_status.sv]
// Purpose: self-checking bench of uecs_top
// Assumes: register port and host model on one clock
// Notes: random endpoint modes, fixed seed
`timescale 1ns/10ps
`default_nettype none
module tb_usb_endpoint_ctrl_status;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] regAddr = 16'h0000;
	logic [7:0] regWdata = 8'h00;
	logic [7:0] regRdata;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [5:0] token = 6'h00;
	logic outPkt = 1'b0;
	logic abortXfer = 1'b0;
	logic ep0IntEnable = 1'b1;
	logic usbEnable, ep0RxPacket, ep0TxDone, ep0StallSent, ep0EarlyEnd;
	logic ep0DataEndDone, ep0StallReq, ep0DataEnd, ep0TxReady;
	logic [5:1] inIntEnable = 5'h00;
	logic [5:1] inIsoMode = 5'h00;
	logic [5:1] inHas = 5'h00;
	logic [5:1] inTxDone, inStallSent, inTokenNoData, inTxReady, inStallMode;
	logic [5:1] inToggleReset;
	int nFail = 0;
	int testsRun = 0;
	int cyc = 0;
	logic [7:0] base;
	localparam logic [15:0] CSR = uecs_pkg::ADDR_CSR;
	uecs_top i_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.usbEnable(usbEnable), .ep0IntEnable(ep0IntEnable),
		.ep0RxPacket(ep0RxPacket),
		.ep0TxDone(ep0TxDone), .ep0StallSent(ep0StallSent),
		.ep0EarlyEnd(ep0EarlyEnd), .ep0DataEndDone(ep0DataEndDone),
		.ep0FifoFlush(), .ep0StallReq(ep0StallReq), .ep0DataEnd(ep0DataEnd),
		.ep0TxReady(ep0TxReady), .ep0RxReady(), .ep0IntReq(),
		.inIntEnable(inIntEnable), .inIsoMode(inIsoMode), .inTxDone(inTxDone),
		.inStallSent(inStallSent), .inTokenNoData(inTokenNoData),
		.inFifoHasPacket(inHas), .inTxReady(inTxReady),
		.inStallMode(inStallMode), .inFifoFlush(),
		.inToggleReset(inToggleReset),
		.inZeroLenReq(), .inIntReq());
	uecs_host_model i_host (.clk(clk), .sysRst(sys_rst), .token(token),
		.outPkt(outPkt), .abortXfer(abortXfer), .ep0StallReq(ep0StallReq),
		.ep0TxReady(ep0TxReady), .ep0DataEnd(ep0DataEnd),
		.inStallMode(inStallMode), .inTxReady(inTxReady),
		.ep0RxPacket(ep0RxPacket), .ep0TxDone(ep0TxDone),
		.ep0StallSent(ep0StallSent), .ep0EarlyEnd(ep0EarlyEnd),
		.ep0DataEndDone(ep0DataEndDone), .inTxDone(inTxDone),
		.inStallSent(inStallSent), .inTokenNoData(inTokenNoData));
	always #5 clk = ~clk;
	task automatic finalReport;
		$display("checks %0d mismatches %0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			nFail++;
			finalReport;
		end
	end
	task automatic check(input string nm, input logic [7:0] seen, exp);
		testsRun++;
		if (seen !== exp) begin
			nFail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [7:0] inView(input int e, input logic [7:0] f);
		return {6'h00, inHas[e], 1'b0} | f;
	endfunction
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 check($sformatf("reg %h", a), regRdata, exp);
	endtask
	// Bits 5:0 tokens, 6 received packet, 7 early end
	task automatic ev(input logic [7:0] v);
		@(posedge clk);
		token <= v[5:0];
		outPkt <= v[6];
		abortXfer <= v[7];
		ep0IntEnable <= 1'($urandom);
		@(posedge clk);
		{abortXfer, outPkt, token} <= 8'h00;
		@(posedge clk);
	endtask
	initial begin
		void'($urandom(32'h952C97D8));
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		inIsoMode <= 5'($urandom);
		inHas <= 5'($urandom);
		inIntEnable <= 5'($urandom);
		rd(uecs_pkg::ADDR_INDEX, 8'h00);
		wr(uecs_pkg::ADDR_CTRL, 8'h01);
		rd(CSR, 8'h00);
		ev(8'h40);
		rd(CSR, 8'h01);
		wr(CSR, 8'h40);
		rd(CSR, 8'h00);
		wr(CSR, 8'h0A);
		rd(CSR, 8'h0A);
		ev(8'h01);
		rd(CSR, 8'h00);
		wr(CSR, 8'h20);
		rd(CSR, 8'h20);
		ev(8'h01);
		rd(CSR, 8'h04);
		wr(CSR, 8'h00);
		rd(CSR, 8'h00);
		ev(8'h80);
		rd(CSR, 8'h10);
		wr(CSR, 8'h80);
		rd(CSR, 8'h00);
		$display("endpoint 0 test done");
		for (int e = 1; e <= 5; e++) begin
			wr(uecs_pkg::ADDR_INDEX, 8'(e));
			base = inView(e, 8'h00);
			wr(CSR, 8'h01);
			rd(CSR, base | 8'h01);
			ev(8'(1 << e));
			rd(CSR, base);
			ev(8'(1 << e));
			rd(CSR, base | 8'h04);
			wr(CSR, 8'h10);
			rd(CSR, base | 8'h10);
			ev(8'(1 << e));
			if (inIsoMode[e]) rd(CSR, base | 8'h14);
			else rd(CSR, base | 8'h30);
			wr(CSR, 8'h09);
			rd(CSR, base);
			wr(CSR, 8'h40);
			#1 check("toggle", 8'(inToggleReset), 8'(1 << (e - 1)));
			rd(CSR, base);
		end
		$display("IN endpoint test done");
		wr(CSR, 8'h01);
		wr(uecs_pkg::ADDR_INDEX, 8'h00);
		rd(CSR, 8'h00);
		wr(16'h6200, 8'($urandom));
		rd(16'h6200, 8'h00);
		wr(uecs_pkg::ADDR_CTRL, 8'h00);
		wr(CSR, 8'h02);
		wr(uecs_pkg::ADDR_CTRL, 8'h01);
		rd(CSR, 8'h00);
		wr(uecs_pkg::ADDR_INDEX, 8'h05);
		rd(CSR, base);
		$display("disable test done");
		finalReport;
	end
endmodule
`default_nettype wire
